// *** src/gpc_top.sv ***
// Strobed register access was left to the implementer.
`default_nettype none
module gpc_top
    import gpc_pkg::*;
#(
    parameter int NPINS = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interrupt
    output logic irq,
    // shared gpio/led pins
    input wire logic [NPINS-1:0] gpio_i,
    output logic [NPINS-1:0] gpio_o,
    output logic [NPINS-1:0] gpio_oe,
    // led sources, high means lit
    input wire logic [NPINS-1:0] led_on,
    // eeprom pins and their sources
    output logic eeprom_data_pin_o,
    output logic eeprom_data_pin_oe,
    input wire logic eeprom_data_pin_i,
    output logic eeprom_clock_pin_o,
    input wire logic ee_data_o,
    input wire logic ee_data_oe,
    input wire logic ee_clk_o,
    output logic ee_data_i,
    // mii debug sources
    input wire logic tx_en,
    input wire logic rx_dv,
    input wire logic tx_clk,
    input wire logic rx_clk,
    // general outputs
    output logic general_output_three,
    output logic general_output_four
);
    gpc_cfg_t cfg_q;
    gpc_cfg_t cfg_d;
    logic [NPINS-1:0] sts_q;
    logic [NPINS-1:0] sts_d;
    logic [NPINS-1:0] en_q;
    logic [NPINS-1:0] en_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [NPINS-1:0] pin_q;
    logic [NPINS-1:0] hit;
    logic [31:0] cfg_word;
    logic [31:0] cfg_new;
    logic sel_cfg;
    logic sel_sts;
    logic sel_en;
    gpc_pin_drv_t drv;
    // reset value of the fields, cut out of the reset word
    localparam gpc_cfg_t CFG_RST = {GPC_CFG_RESET[30:28],
        GPC_CFG_RESET[26:24], GPC_CFG_RESET[22:20], GPC_CFG_RESET[18:16],
        GPC_CFG_RESET[10:8], GPC_CFG_RESET[4:3], GPC_CFG_RESET[2:0]};

    // address decode
    assign sel_cfg = (reg_addr == GPC_CFG_OFFS);
    assign sel_sts = (reg_addr == GPC_IRQ_STS_OFFS);
    assign sel_en = (reg_addr == GPC_IRQ_EN_OFFS);

    // configuration word as seen by software
    assign cfg_word = {1'b0, cfg_q.led_select_bits,
                       1'b0, cfg_q.pin_irq_polarity,
                       1'b0, cfg_q.eeprom_pin_function_sel,
                       1'b0, cfg_q.pin_buffer_type,
                       5'h00, cfg_q.pin_direction,
                       3'h0, cfg_q.general_output_data,
                       pin_q};
    // only defined fields take written values
    assign cfg_new = reg_wdata & GPC_CFG_WMASK;

    // next configuration
    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr && sel_cfg) begin
            cfg_d.led_select_bits = cfg_new[30:28];
            cfg_d.pin_irq_polarity = cfg_new[26:24];
            cfg_d.eeprom_pin_function_sel = cfg_new[22:20];
            cfg_d.pin_buffer_type = cfg_new[18:16];
            cfg_d.pin_direction = cfg_new[10:8];
            cfg_d.general_output_data = cfg_new[4:3];
            cfg_d.pin_io_data = cfg_new[2:0];
        end
    end

    // sticky status, set wins over write-one clear; enables plain
    assign sts_d = hit | (sts_q & ~((reg_wr && sel_sts) ?
                   reg_wdata[NPINS-1:0] : {NPINS{1'b0}}));
    assign en_d = (reg_wr && sel_en) ? reg_wdata[NPINS-1:0] : en_q;
    assign irq = |(sts_q & en_q);

    // read data mux
    assign rdata_d = !reg_rd ? 32'h0000_0000 :
        sel_cfg ? cfg_word :
        sel_sts ? {{(32-NPINS){1'b0}}, sts_q} :
        sel_en ? {{(32-NPINS){1'b0}}, en_q} : 32'h0000_0000;
    assign reg_rdata = rdata_q;

    // per-pin drive, filter and sampling
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            logic val;
            logic act;
            // led output overrides gpio; led lit pulls low
            assign val = cfg_q.led_select_bits[g] ? ~led_on[g]
                         : cfg_q.pin_io_data[g];
            assign drv.o[g] = val;
            // led pins always drive; gpio only as output, open drain
            // drives low only
            assign drv.oe[g] = cfg_q.led_select_bits[g] ? 1'b1 :
                cfg_q.pin_direction[g] &
                (cfg_q.pin_buffer_type[g] | ~val);
            assign act = cfg_q.pin_irq_polarity[g] ? pin_q[g]
                         : ~pin_q[g];
            gpc_irq_filter u_filt (
                .core_clk(core_clk),
                .resetn(resetn),
                .active(act),
                .hit(hit[g])
            );
        end
    endgenerate
    assign gpio_o = drv.o;
    assign gpio_oe = drv.oe;

    // general outputs from their data bits
    assign general_output_three = cfg_q.general_output_data[0];
    assign general_output_four = cfg_q.general_output_data[1];
    assign ee_data_i = eeprom_data_pin_i;

    // eeprom pin routing
    gpc_eeprom_mux u_mux (
        .sel(cfg_q.eeprom_pin_function_sel),
        .ee_data_o(ee_data_o),
        .ee_data_oe(ee_data_oe),
        .ee_clk_o(ee_clk_o),
        .gpo(cfg_q.general_output_data),
        .tx_en(tx_en),
        .rx_dv(rx_dv),
        .tx_clk(tx_clk),
        .rx_clk(rx_clk),
        .data_o(eeprom_data_pin_o),
        .data_oe(eeprom_data_pin_oe),
        .clk_o(eeprom_clock_pin_o)
    );

    // registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= CFG_RST;
            sts_q <= '0;
            en_q <= '0;
            rdata_q <= 32'h0000_0000;
            pin_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            sts_q <= sts_d;
            en_q <= en_d;
            rdata_q <= rdata_d;
            pin_q <= gpio_i;
        end
    end
endmodule : gpc_top
`default_nettype wire

// *** inc/gpc_pkg.sv ***
`default_nettype none
package gpc_pkg;
    // register map, one aligned word each
    localparam logic [7:0] GPC_CFG_OFFS = 8'hD0;
    localparam logic [7:0] GPC_IRQ_STS_OFFS = 8'hC0;
    localparam logic [7:0] GPC_IRQ_EN_OFFS = 8'hC4;
    // field positions
    localparam int GPC_LED_LSB = 28;
    localparam int GPC_POL_LSB = 24;
    localparam int GPC_FUNC_LSB = 20;
    localparam int GPC_BUF_LSB = 16;
    localparam int GPC_DIR_LSB = 8;
    localparam int GPC_GPO_LSB = 3;
    localparam int GPC_IO_LSB = 0;
    // writable bits of the configuration word
    localparam logic [31:0] GPC_CFG_WMASK = 32'h7777_071F;
    localparam logic [31:0] GPC_CFG_RESET = 32'h0000_0000;
    // interrupt filter: active for more than 80 ns
    localparam int GPC_CLK_MHZ = 25;
    localparam int GPC_IRQ_MIN_NS = 80;
    localparam int GPC_IRQ_FILT_CYC = (GPC_IRQ_MIN_NS * GPC_CLK_MHZ) / 1000 + 1;
    // eeprom pin functions
    typedef enum logic [2:0] {
        GPC_FN_EEPROM = 3'h0,
        GPC_FN_GPO = 3'h1,
        GPC_FN_RSV2 = 3'h2,
        GPC_FN_GENERAL_OUTPUT_THREE_RXDV = 3'h3,
        GPC_FN_RSV4 = 3'h4,
        GPC_FN_TXEN_GENERAL_OUTPUT_FOUR = 3'h5,
        GPC_FN_TXEN_RXDV = 3'h6,
        GPC_FN_CLKS = 3'h7
    } gpc_func_t;
    // configuration fields
    typedef struct packed {
        logic [2:0] led_select_bits;
        logic [2:0] pin_irq_polarity;
        logic [2:0] eeprom_pin_function_sel;
        logic [2:0] pin_buffer_type;
        logic [2:0] pin_direction;
        logic [1:0] general_output_data;
        logic [2:0] pin_io_data;
    } gpc_cfg_t;
    // shared pin driver signals
    typedef struct packed {
        logic [2:0] o;
        logic [2:0] oe;
    } gpc_pin_drv_t;
endpackage : gpc_pkg
`default_nettype wire

// *** src/gpc_irq_filter.sv ***
`default_nettype none
module gpc_irq_filter
    import gpc_pkg::*;
#(
    parameter int FILT_CYC = GPC_IRQ_FILT_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // level in, qualified event out
    input wire logic active,
    output logic hit
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    // count cycles of continuous activity, saturate at the limit
    assign cnt_d = !active ? 4'h0 :
                   (cnt_q == 4'(FILT_CYC)) ? cnt_q : cnt_q + 4'h1;
    assign hit = (cnt_q == 4'(FILT_CYC));
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : gpc_irq_filter
`default_nettype wire

// *** src/gpc_eeprom_mux.sv ***
`default_nettype none
module gpc_eeprom_mux
    import gpc_pkg::*;
(
    // function select
    input wire logic [2:0] sel,
    // sources
    input wire logic ee_data_o,
    input wire logic ee_data_oe,
    input wire logic ee_clk_o,
    input wire logic [1:0] gpo,
    input wire logic tx_en,
    input wire logic rx_dv,
    input wire logic tx_clk,
    input wire logic rx_clk,
    // pins
    output logic data_o,
    output logic data_oe,
    output logic clk_o
);
    // data pin function
    assign data_o = (sel == GPC_FN_EEPROM) ? ee_data_o :
        (sel == GPC_FN_GPO || sel == GPC_FN_GENERAL_OUTPUT_THREE_RXDV) ? gpo[0] :
        (sel == GPC_FN_CLKS) ? tx_clk : tx_en;
    assign data_oe = (sel == GPC_FN_EEPROM) ? ee_data_oe : 1'b1;
    // clock pin function
    assign clk_o = (sel == GPC_FN_EEPROM) ? ee_clk_o :
        (sel == GPC_FN_GPO || sel == GPC_FN_TXEN_GENERAL_OUTPUT_FOUR) ? gpo[1] :
        (sel == GPC_FN_CLKS) ? rx_clk : rx_dv;
endmodule : gpc_eeprom_mux
`default_nettype wire

// *** dv/gpc_chk.sv ***
`default_nettype none
module gpc_chk
    import gpc_pkg::*;
#(
    parameter int NPINS = 3
) (
    // clock, reset and register writes
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    // outputs under watch, with the pin and led inputs
    input wire logic irq,
    input wire logic [NPINS-1:0] gpio_i,
    input wire logic [NPINS-1:0] gpio_o,
    input wire logic [NPINS-1:0] gpio_oe,
    input wire logic [NPINS-1:0] led_on,
    input wire logic general_output_three,
    input wire logic general_output_four
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] cfg_q;
    logic [2:0] en_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // shadow copy of the written words
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= '0;
            en_q <= '0;
        end else if (reg_wr && reg_addr == GPC_CFG_OFFS) begin
            cfg_q <= reg_wdata;
        end else if (reg_wr && reg_addr == GPC_IRQ_EN_OFFS) begin
            en_q <= reg_wdata[2:0];
        end
    end
    // pin drivers and interrupt
    a_gpo_follow: assert property (reg_wr && reg_addr == GPC_CFG_OFFS
        |=> {general_output_four, general_output_three} == cfg_q[4:3])
        else $error("general output wrong");
    a_input_off: assert property (
        (~cfg_q[10:8] & ~cfg_q[30:28] & gpio_oe) == 0)
        else $error("input pin driven");
    a_push_pull: assert property (
        (~cfg_q[30:28] & cfg_q[10:8] & cfg_q[18:16]
        & (~gpio_oe | gpio_o ^ cfg_q[2:0])) == 0) else $error("push-pull");
    a_open_drain: assert property (
        (~cfg_q[30:28] & cfg_q[10:8] & ~cfg_q[18:16]
        & (gpio_oe ^ ~cfg_q[2:0] | gpio_oe & gpio_o)) == 0)
        else $error("open drain");
    a_led_drive: assert property (
        (cfg_q[30:28] & (~gpio_oe | gpio_o ^ ~led_on)) == 0)
        else $error("led drive");
    a_irq_masked: assert property (en_q == 0 |-> !irq)
        else $error("irq while masked");
    a_irq_raise: assert property (
        (en_q[0] && gpio_i[0] == cfg_q[24])[*5] |-> ##[0:3] irq)
        else $error("irq missing");
    a_irq_sticky: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("irq dropped by itself");
endmodule : gpc_chk
bind gpc_top gpc_chk #(.NPINS(NPINS)) u_gpc_chk (.*);
`default_nettype wire

// *** dv/gpc_pins.sv ***
`default_nettype none
module gpc_pins (
    // device side of the pins
    input wire logic [2:0] gpio_o,
    input wire logic [2:0] gpio_oe,
    input wire logic eeprom_data_pin_o,
    input wire logic eeprom_data_pin_oe,
    output logic [2:0] gpio_i,
    output logic eeprom_data_pin_i,
    // outside drivers, an undriven pin is pulled up
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_v
);
    timeunit 1ns;
    timeprecision 1ns;
    // resolved levels, the device wins on contention
    assign gpio_i = gpio_oe & gpio_o | ~gpio_oe & (~ext_en | ext_v);
    assign eeprom_data_pin_i = eeprom_data_pin_oe ? eeprom_data_pin_o : 1'h1;
endmodule : gpc_pins
`default_nettype wire

// *** dv/gpc_top_test.sv ***
`default_nettype none
module gpc_top_test
    import gpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, resetn, reg_wr, reg_rd, rd_d, irq, ed, ec;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, r, exp_w;
    logic [2:0] gpio_i, gpio_o, gpio_oe, led_on, ext_en, ext_v, f;
    logic eeprom_data_pin_o, eeprom_data_pin_oe, eeprom_data_pin_i;
    logic eeprom_clock_pin_o, ee_data_o, ee_data_oe, ee_clk_o, ee_data_i;
    logic tx_en, rx_dv, tx_clk, rx_clk;
    logic general_output_three, general_output_four;
    logic [8:0] s;
    logic [2:0] fns[6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    logic [31:0] exp_q[$];
    int n_mismatch = 0;
    int tests_run = 0;
    gpc_top u_gpc_top (.*);
    gpc_pins u_gpc_pins (.*);
    // clock
    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test;
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // one register access, a read notes its expected word
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [31:0] v);
        if (!w) exp_q.push_back(v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge core_clk);
        {reg_wr, reg_rd} <= 2'h0;
    endtask : acc
    // read data stand in the cycle after the strobe
    always @(posedge core_clk) begin
        rd_d <= reg_rd;
        if (rd_d) chk(reg_rdata, exp_q.pop_front());
    end
    initial begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, led_on, ext_en} = '0;
        {ext_v, ee_data_o, ee_data_oe, ee_clk_o, tx_en, rx_dv} = '0;
        {tx_clk, rx_clk} = '0;
        void'($urandom(20));
        repeat (6) @(posedge core_clk);
        resetn <= 1'h1;
        repeat (2) @(posedge core_clk);
        acc(1'h0, GPC_CFG_OFFS, 32'h7);
        acc(1'h0, 8'h10, 32'h0);
        // random pin modes, reserved bits written as ones
        repeat (6) begin
            r = $urandom;
            s = 9'($urandom);
            led_on <= s[2:0];
            acc(1'h1, GPC_CFG_OFFS, r & 32'h7707_001F | 32'h8888_FFE0);
            exp_w = r & 32'h7707_001F | 32'h0000_0700;
            exp_w[2:0] = r[30:28] & ~s[2:0] | ~r[30:28] & r[2:0];
            repeat (3) @(posedge core_clk);
            acc(1'h0, GPC_CFG_OFFS, exp_w);
        end
        // every legal pin function with random sources
        foreach (fns[i]) begin
            @(posedge core_clk);
            f = fns[i];
            s = 9'($urandom);
            {ee_data_o, ee_clk_o, tx_en, rx_dv, tx_clk, rx_clk} <= s[8:3];
            ee_data_oe <= s[2];
            acc(1'h1, GPC_CFG_OFFS, {9'h0, f, 15'h0, s[1:0], 3'h0});
            ed = f == 3'h0 ? s[8] : f == 3'h7 ? s[4] : f[2] ? s[6] : s[0];
            ec = f == 3'h0 ? s[7] : f == 3'h7 ? s[3] : f[1] ? s[5] : s[1];
            #1;
            chk(32'({eeprom_data_pin_o, eeprom_clock_pin_o}),
                32'({ed, ec}));
            chk(32'({general_output_four, general_output_three}),
                32'(s[1:0]));
            chk(32'({eeprom_data_pin_oe, ee_data_i}),
                32'({f != 3'h0 | s[2], (f != 3'h0 | s[2]) ? ed : 1'h1}));
        end
        // level interrupts: short pulse, hold, clear, mask
        ext_v <= 3'h6;
        ext_en <= 3'h7;
        acc(1'h1, GPC_CFG_OFFS, 32'h0100_0000);
        acc(1'h1, GPC_IRQ_EN_OFFS, 32'h1);
        repeat (6) @(posedge core_clk);
        acc(1'h1, GPC_IRQ_STS_OFFS, 32'h7);
        ext_v <= 3'h7;
        repeat (2) @(posedge core_clk);
        ext_v <= 3'h6;
        repeat (6) @(posedge core_clk);
        acc(1'h0, GPC_IRQ_STS_OFFS, 32'h0);
        ext_v <= 3'h7;
        repeat (8) @(posedge core_clk);
        #1 chk(32'(irq), 32'h1);
        @(posedge core_clk);
        ext_v <= 3'h6;
        repeat (6) @(posedge core_clk);
        acc(1'h1, GPC_IRQ_STS_OFFS, 32'h1);
        acc(1'h0, GPC_IRQ_STS_OFFS, 32'h0);
        #1 chk(32'(irq), 32'h0);
        @(posedge core_clk);
        ext_v <= 3'h4;
        repeat (8) @(posedge core_clk);
        acc(1'h0, GPC_IRQ_STS_OFFS, 32'h2);
        #1 chk(32'(irq), 32'h0);
        acc(1'h1, GPC_IRQ_EN_OFFS, 32'h2);
        #1 chk(32'(irq), 32'h1);
        stop_test();
    end
endmodule : gpc_top_test
`default_nettype wire
